/* verilog/adcmcs_map.svh */
/*
  Constants of the converter control block: serial command layout, register
  addresses and field positions, reset values, scaling figures and timing.
  Assumes a 100 MHz system clock on both ends of the serial link.
*/
`ifndef ADCMCS_MAP_SVH
`define ADCMCS_MAP_SVH

`define ADCMCS_CLK_MHZ 100
`define ADCMCS_SETTLE_NS 20000
`define ADCMCS_SETTLE_CYC ((`ADCMCS_SETTLE_NS * `ADCMCS_CLK_MHZ + 999) / 1000)
`define ADCMCS_RESET_WAIT_US 500
`define ADCMCS_RESET_WAIT_CYC (`ADCMCS_RESET_WAIT_US * `ADCMCS_CLK_MHZ)
`define ADCMCS_RESET_ONES 7'd64
`define ADCMCS_SCLK_HALF 8

`define ADCMCS_CMD_READ_DATA 8'h44
`define ADCMCS_COMM_WEN_BIT 7
`define ADCMCS_COMM_RW_BIT 6

`define ADCMCS_ADDR_STATUS 6'h00
`define ADCMCS_ADDR_MODE 6'h01
`define ADCMCS_ADDR_IFMODE 6'h02
`define ADCMCS_ADDR_DATA 6'h04
`define ADCMCS_ADDR_CHEN 6'h10
`define ADCMCS_ADDR_OFFSET 6'h30
`define ADCMCS_ADDR_GAIN 6'h38

`define ADCMCS_MODE_REF_EN 15
`define ADCMCS_MODE_LSB 4
`define ADCMCS_CLKSEL_LSB 2
`define ADCMCS_IFMODE_APPEND 6
`define ADCMCS_CHEN_BIPOLAR 4
`define ADCMCS_STATUS_RDY 7

`define ADCMCS_MODE_CONT 3'h0
`define ADCMCS_MODE_SINGLE 3'h1
`define ADCMCS_MODE_STANDBY 3'h2
`define ADCMCS_MODE_PDOWN 3'h3
`define ADCMCS_MODE_INT_ZERO 3'h4
`define ADCMCS_MODE_INT_FULL 3'h5
`define ADCMCS_MODE_SYS_ZERO 3'h6
`define ADCMCS_MODE_SYS_FULL 3'h7

`define ADCMCS_MODE_RST 16'h8020
`define ADCMCS_IFMODE_RST 16'h0000
`define ADCMCS_CHEN_RST 8'h11
`define ADCMCS_OFFSET_RST 24'h80_0000
`define ADCMCS_GAIN_RST 24'h55_5555
`define ADCMCS_MIDSCALE 24'h80_0000
`define ADCMCS_GAIN_SHIFT 22
`define ADCMCS_FS_NUM 48'h2000_0000_0000

`define ADCMCS_HOST_CTRL 3'h0
`define ADCMCS_HOST_WDATA 3'h1
`define ADCMCS_HOST_RDATA 3'h2
`define ADCMCS_HOST_STATUS 3'h3
`define ADCMCS_HOST_CFG 3'h4
`define ADCMCS_CTRL_READ 6
`define ADCMCS_CTRL_RESET 7
`define ADCMCS_CTRL_LEN_LSB 8

`endif

/* verilog/adcmcs_pkg.sv */
/*
  Types shared by both ends of the converter control link.
  Assumes adcmcs_map.svh supplies the numeric constants.
*/
package adcmcs_pkg;
  typedef enum logic [2:0] {CV_IDLE, CV_CONV, CV_UPD, CV_CAL, CV_DIV} adcmcs_conv_t;
  typedef enum logic [1:0] {SP_CMD, SP_WRITE, SP_READ} adcmcs_spi_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_WAIT} adcmcs_host_t;
endpackage : adcmcs_pkg

/* verilog/adcmcs_if.sv */
/*
  Four-wire serial link between the converter and its controller.
  Assumes the data-out line has a pull-up while the converter floats it.
*/
`timescale 1ns/1ns
interface adcmcs_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  wire dout_line = dout_oe ? dout : 1'b1;
  modport device (input cs_n, input sclk, input din, output dout, output dout_oe);
  modport host (output cs_n, output sclk, output din, input dout_line);
endinterface : adcmcs_if

/* verilog/adcmcs_device.sv */
/*
  Converter end: serial slave, register file, single conversion sequencer,
  calibration and power handling. Assumes serial mode 3 (clock idles high,
  data sampled on rising edges) with at least 8 system clocks per half period.
*/
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "adcmcs_map.svh"
module adcmcs_device #(
  parameter int SETTLE_CYC = `ADCMCS_SETTLE_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  adcmcs_if.device link,
  input wire logic signed [23:0] raw_code,
  output logic [1:0] conv_channel,
  output logic conv_active,
  output logic ain_pos_connected,
  output logic ref_on,
  output logic xtal_on,
  output logic gpio_hiz,
  output logic powered_down
);
  import adcmcs_pkg::*;

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [2:0] s1_q, s2_q;
  logic sclk_prev_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 3'b110;
      s2_q <= 3'b110;
      sclk_prev_q <= 1'b1;
    end else begin
      s1_q <= {link.cs_n, link.sclk, link.din};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[1];
    end
  end
  wire cs_n = s2_q[2];
  wire din = s2_q[0];
  wire rise = s2_q[1] & ~sclk_prev_q & ~cs_n;
  wire fall = ~s2_q[1] & sclk_prev_q & ~cs_n;

  // ==========================================================
  // Reset pattern detector
  logic [6:0] ones_q;
  wire soft_rst = rise & din & (ones_q == `ADCMCS_RESET_ONES - 7'd1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) ones_q <= 7'd0;
    else if (cs_n || soft_rst) ones_q <= 7'd0;
    else if (rise) ones_q <= din ? ones_q + 7'd1 : 7'd0;
  end

  // ==========================================================
  // Register state
  logic [15:0] mode_q, ifmode_q;
  logic [7:0] chen_q;
  logic [23:0] offset_q, gain_q, data_q;
  logic [1:0] stat_ch_q, ch_q;
  logic rdy_n_q, pd_q, dout_q;
  adcmcs_conv_t cv_q;
  adcmcs_spi_t sp_q;
  logic [5:0] cnt_q, len_q, addr_q;
  logic [23:0] rx_q;
  logic [31:0] tx_q;

  wire [2:0] cur_mode = mode_q[`ADCMCS_MODE_LSB +: 3];
  wire append = ifmode_q[`ADCMCS_IFMODE_APPEND];
  wire int_cal = (cv_q != CV_IDLE) && (cur_mode == `ADCMCS_MODE_INT_ZERO);
  wire [7:0] status = {rdy_n_q, 5'd0, stat_ch_q};
  wire is_coef = (addr_q == `ADCMCS_ADDR_OFFSET) || (addr_q == `ADCMCS_ADDR_GAIN);

  function automatic logic [5:0] reg_len(input logic [5:0] a, input logic app);
    if (a == `ADCMCS_ADDR_MODE || a == `ADCMCS_ADDR_IFMODE) reg_len = 6'd16;
    else if (a == `ADCMCS_ADDR_DATA) reg_len = app ? 6'd32 : 6'd24;
    else if (a == `ADCMCS_ADDR_OFFSET || a == `ADCMCS_ADDR_GAIN) reg_len = 6'd24;
    else reg_len = 6'd8;
  endfunction : reg_len

  // ==========================================================
  // Serial engine
  wire [7:0] cmd_byte = {rx_q[6:0], din};
  wire [5:0] cmd_addr = cmd_byte[5:0];
  wire [5:0] cmd_len = reg_len(cmd_addr, append);
  wire [31:0] rd_val =
    (cmd_addr == `ADCMCS_ADDR_STATUS) ? {24'd0, status} :
    (cmd_addr == `ADCMCS_ADDR_MODE) ? {16'd0, mode_q} :
    (cmd_addr == `ADCMCS_ADDR_IFMODE) ? {16'd0, ifmode_q} :
    (cmd_addr == `ADCMCS_ADDR_DATA) ? (append ? {data_q, status} : {8'd0, data_q}) :
    (cmd_addr == `ADCMCS_ADDR_CHEN) ? {24'd0, chen_q} :
    (cmd_addr == `ADCMCS_ADDR_OFFSET) ? {8'd0, offset_q} :
    (cmd_addr == `ADCMCS_ADDR_GAIN) ? {8'd0, gain_q} : 32'd0;
  wire srise = rise & ~pd_q;
  wire cmd_done = srise && sp_q == SP_CMD && cnt_q == 6'd7 && !cmd_byte[`ADCMCS_COMM_WEN_BIT];
  wire last_bit = srise && cnt_q == len_q - 6'd1;
  wire wr_fire = last_bit && sp_q == SP_WRITE && !(is_coef && int_cal);
  wire [23:0] wval = {rx_q[22:0], din};
  wire data_read_done = last_bit && sp_q == SP_READ && addr_q == `ADCMCS_ADDR_DATA;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sp_q <= SP_CMD;
      cnt_q <= 6'd0;
      len_q <= 6'd8;
      addr_q <= 6'd0;
      rx_q <= 24'd0;
      tx_q <= 32'd0;
    end else if (cs_n || soft_rst || pd_q) begin
      sp_q <= SP_CMD;
      cnt_q <= 6'd0;
    end else if (srise) begin
      rx_q <= wval;
      cnt_q <= cnt_q + 6'd1;
      if (sp_q == SP_CMD && cnt_q == 6'd7) begin
        cnt_q <= 6'd0;
        if (cmd_done) begin
          addr_q <= cmd_addr;
          len_q <= cmd_len;
          tx_q <= rd_val << (6'd32 - cmd_len);
          sp_q <= cmd_byte[`ADCMCS_COMM_RW_BIT] ? SP_READ : SP_WRITE;
        end
      end else if (sp_q != SP_CMD && last_bit) begin
        sp_q <= SP_CMD;
        cnt_q <= 6'd0;
      end
    end else if (fall && sp_q == SP_READ) begin
      tx_q <= tx_q << 1;
    end
  end

  // Data-out flop: shifted bit during a read, ready level otherwise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) dout_q <= 1'b1;
    else if (fall && sp_q == SP_READ) dout_q <= tx_q[31];
    else if (sp_q != SP_READ) dout_q <= rdy_n_q;
  end
  assign link.dout = dout_q;
  assign link.dout_oe = ~cs_n;

  // ==========================================================
  // Mode register decode
  wire mode_wr = wr_fire && addr_q == `ADCMCS_ADDR_MODE;
  wire [2:0] new_mode = wval[`ADCMCS_MODE_LSB +: 3];
  wire new_cal = new_mode[2] && new_mode != `ADCMCS_MODE_INT_FULL;
  wire pd_go = mode_wr && new_mode == `ADCMCS_MODE_PDOWN && cur_mode == `ADCMCS_MODE_STANDBY;
  wire mode_ok = new_mode != `ADCMCS_MODE_INT_FULL && (new_mode != `ADCMCS_MODE_PDOWN || pd_go);
  wire start = mode_wr && mode_ok && (new_mode == `ADCMCS_MODE_SINGLE || new_cal);
  wire clr = soft_rst | pd_go;

  // ==========================================================
  // Channel selection and scaling
  function automatic logic [2:0] next_ch(input logic [3:0] en, input logic [2:0] from);
    next_ch = 3'd4;
    for (int i = 3; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) next_ch = 3'(i);
    end
  endfunction : next_ch
  wire [2:0] first_ch = next_ch(chen_q[3:0], 3'd0);
  wire [2:0] follow_ch = next_ch(chen_q[3:0], {1'b0, ch_q} + 3'd1);

  logic signed [25:0] adj;
  logic signed [51:0] prod, res;
  assign adj = {{2{raw_code[23]}}, raw_code} - {2'b00, offset_q} + {2'b00, `ADCMCS_MIDSCALE};
  assign prod = adj * $signed({1'b0, gain_q});
  assign res = chen_q[`ADCMCS_CHEN_BIPOLAR] ?
    (prod >>> `ADCMCS_GAIN_SHIFT) + 52'sh0080_0000 : (prod >>> (`ADCMCS_GAIN_SHIFT - 1));
  wire [23:0] scaled = res < 0 ? 24'h00_0000 : (|res[51:24] ? 24'hFF_FFFF : res[23:0]);

  // ==========================================================
  // Conversion and calibration sequencer
  logic [15:0] tmr_q;
  logic [5:0] div_cnt_q;
  logic [47:0] div_n_q;
  logic [25:0] div_r_q;
  logic [24:0] div_d_q;
  wire tmr_end = tmr_q == 16'(SETTLE_CYC - 1);
  wire [25:0] div_t = {div_r_q[24:0], div_n_q[47]};
  wire div_ge = div_t >= {1'b0, div_d_q};
  wire cal_zero = cv_q == CV_CAL && tmr_end && cur_mode != `ADCMCS_MODE_SYS_FULL;
  wire div_end = cv_q == CV_DIV && div_cnt_q == 6'd47;
  wire upd_last = cv_q == CV_UPD && follow_ch[2];
  wire cv_finish = upd_last | cal_zero | div_end | (start && first_ch[2]);
  wire [23:0] div_q = {div_n_q[22:0], div_ge};
  wire [23:0] gain_new = (|div_n_q[46:23]) ? 24'hFF_FFFF : div_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cv_q <= CV_IDLE;
      ch_q <= 2'd0;
      tmr_q <= 16'd0;
    end else if (clr) begin
      cv_q <= CV_IDLE;
      ch_q <= 2'd0;
      tmr_q <= 16'd0;
    end else if (start && !first_ch[2]) begin
      cv_q <= new_cal ? CV_CAL : CV_CONV;
      ch_q <= first_ch[1:0];
      tmr_q <= 16'd0;
    end else begin
      tmr_q <= tmr_q + 16'd1;
      case (cv_q)
        CV_CONV: if (tmr_end) cv_q <= CV_UPD;
        CV_UPD: begin
          tmr_q <= 16'd0;
          cv_q <= follow_ch[2] ? CV_IDLE : CV_CONV;
          ch_q <= follow_ch[1:0];
        end
        CV_CAL: if (tmr_end) cv_q <= cal_zero ? CV_IDLE : CV_DIV;
        CV_DIV: if (div_end) cv_q <= CV_IDLE;
        default: tmr_q <= 16'd0;
      endcase
    end
  end

  // Restoring divider for the full-scale gain, one quotient bit per cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q <= 6'd0;
      div_n_q <= 48'd0;
      div_r_q <= 26'd0;
      div_d_q <= 25'd0;
    end else if (cv_q == CV_CAL) begin
      div_cnt_q <= 6'd0;
      div_n_q <= `ADCMCS_FS_NUM;
      div_r_q <= 26'd0;
      div_d_q <= adj[25] ? 25'd0 : adj[24:0];
    end else if (cv_q == CV_DIV) begin
      div_cnt_q <= div_cnt_q + 6'd1;
      div_r_q <= div_ge ? div_t - {1'b0, div_d_q} : div_t;
      div_n_q <= {div_n_q[46:0], div_ge};
    end
  end

  // Ready flag, result and channel tag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdy_n_q <= 1'b1;
      data_q <= 24'd0;
      stat_ch_q <= 2'd0;
    end else if (clr) begin
      rdy_n_q <= 1'b1;
      data_q <= 24'd0;
      stat_ch_q <= 2'd0;
    end else if (start) begin
      rdy_n_q <= 1'b1;
    end else if (cv_q == CV_CONV && tmr_end) begin
      rdy_n_q <= 1'b1;
    end else if (cv_q == CV_UPD) begin
      data_q <= scaled;
      stat_ch_q <= ch_q;
      rdy_n_q <= 1'b0;
    end else if (cal_zero || div_end) begin
      rdy_n_q <= 1'b0;
    end else if (data_read_done) begin
      rdy_n_q <= 1'b1;
    end
  end

  // ==========================================================
  // Register file; power-down wipes everything to power-on values
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `ADCMCS_MODE_RST;
      ifmode_q <= `ADCMCS_IFMODE_RST;
      chen_q <= `ADCMCS_CHEN_RST;
      offset_q <= `ADCMCS_OFFSET_RST;
      gain_q <= `ADCMCS_GAIN_RST;
    end else if (clr) begin
      // Synchronous wipe, kept apart from the pin reset
      mode_q <= `ADCMCS_MODE_RST;
      ifmode_q <= `ADCMCS_IFMODE_RST;
      chen_q <= `ADCMCS_CHEN_RST;
      offset_q <= `ADCMCS_OFFSET_RST;
      gain_q <= `ADCMCS_GAIN_RST;
    end else begin
      if (mode_wr && mode_ok) mode_q <= wval[15:0];
      else if (cv_finish) mode_q[`ADCMCS_MODE_LSB +: 3] <= `ADCMCS_MODE_STANDBY;
      if (wr_fire && addr_q == `ADCMCS_ADDR_IFMODE) ifmode_q <= wval[15:0];
      if (wr_fire && addr_q == `ADCMCS_ADDR_CHEN) chen_q <= wval[7:0];
      if (cal_zero) offset_q <= raw_code + `ADCMCS_MIDSCALE;
      else if (wr_fire && addr_q == `ADCMCS_ADDR_OFFSET) offset_q <= wval;
      if (div_end) gain_q <= gain_new;
      else if (wr_fire && addr_q == `ADCMCS_ADDR_GAIN) gain_q <= wval;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) pd_q <= 1'b0;
    else if (soft_rst) pd_q <= 1'b0;
    else if (pd_go) pd_q <= 1'b1;
  end

  // ==========================================================
  // Analog-side controls
  assign conv_channel = ch_q;
  assign conv_active = cv_q != CV_IDLE;
  assign ain_pos_connected = ~(cv_q == CV_CAL && cur_mode == `ADCMCS_MODE_INT_ZERO);
  assign ref_on = ~pd_q & mode_q[`ADCMCS_MODE_REF_EN];
  assign xtal_on = ~pd_q & (mode_q[`ADCMCS_CLKSEL_LSB +: 2] != 2'b00);
  assign gpio_hiz = pd_q;
  assign powered_down = pd_q;
endmodule : adcmcs_device

/* verilog/adcmcs_host.sv */
/*
  Controller end: drives the serial link from a small register port.
  Assumes single-cycle write and read strobes with read data one cycle later.
*/
`timescale 1ns/1ns
`include "adcmcs_map.svh"
module adcmcs_host #(
  parameter int SCLK_HALF = `ADCMCS_SCLK_HALF,
  parameter int RESET_WAIT_CYC = `ADCMCS_RESET_WAIT_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  adcmcs_if.host link,
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import adcmcs_pkg::*;

  // ==========================================================
  // Data-out synchroniser
  logic dout_s1_q, dout_s2_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dout_s1_q <= 1'b1;
      dout_s2_q <= 1'b1;
    end else begin
      dout_s1_q <= link.dout_line;
      dout_s2_q <= dout_s1_q;
    end
  end

  // ==========================================================
  // Transfer sequencer
  adcmcs_host_t hs_q;
  logic [31:0] wdata_q, rx_q, rdata_q;
  logic [39:0] sh_q;
  logic [6:0] bits_q, total_q;
  logic [5:0] len_q;
  logic [15:0] half_q;
  logic [31:0] wait_q;
  logic sclk_q, cs_n_q, din_q, rst_seq_q, tie_low_q;

  wire ctrl_go = wr && addr == `ADCMCS_HOST_CTRL && hs_q == HS_IDLE;
  wire [5:0] go_len = wdata[`ADCMCS_CTRL_LEN_LSB +: 6];
  wire go_read = wdata[`ADCMCS_CTRL_READ];
  wire go_reset = wdata[`ADCMCS_CTRL_RESET];
  wire [7:0] go_cmd = {1'b0, go_read, wdata[5:0]};
  wire half_end = hs_q == HS_SHIFT && half_q == 16'(SCLK_HALF - 1);
  wire rising = half_end && !sclk_q;
  wire falling = half_end && sclk_q;
  wire last = rising && bits_q == total_q - 7'd1;
  wire [31:0] len_mask = 32'hFFFF_FFFF >> (6'd32 - len_q);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hs_q <= HS_IDLE;
      sh_q <= 40'd0;
      bits_q <= 7'd0;
      total_q <= 7'd8;
      len_q <= 6'd8;
      half_q <= 16'd0;
      wait_q <= 32'd0;
      rst_seq_q <= 1'b0;
      rx_q <= 32'd0;
      rdata_q <= 32'd0;
    end else begin
      case (hs_q)
        HS_IDLE: if (ctrl_go) begin
          hs_q <= HS_SHIFT;
          rst_seq_q <= go_reset;
          len_q <= go_len;
          total_q <= go_reset ? `ADCMCS_RESET_ONES : 7'd8 + {1'b0, go_len};
          sh_q <= {go_cmd, go_read ? 32'd0 : wdata_q << (6'd32 - go_len)};
          bits_q <= 7'd0;
          half_q <= 16'd0;
        end
        HS_SHIFT: begin
          half_q <= half_end ? 16'd0 : half_q + 16'd1;
          if (falling) sh_q <= sh_q << 1;
          if (rising) begin
            rx_q <= {rx_q[30:0], dout_s2_q};
            bits_q <= bits_q + 7'd1;
          end
          if (last) begin
            rdata_q <= {rx_q[30:0], dout_s2_q} & len_mask;
            wait_q <= 32'd0;
            hs_q <= rst_seq_q ? HS_WAIT : HS_IDLE;
          end
        end
        HS_WAIT: begin
          wait_q <= wait_q + 32'd1;
          if (wait_q == 32'(RESET_WAIT_CYC - 1)) hs_q <= HS_IDLE;
        end
        default: hs_q <= HS_IDLE;
      endcase
    end
  end

  // Data in changes only on falling edges during a transfer so the converter samples stable data
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      din_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else begin
      if (half_end) sclk_q <= ~sclk_q;
      else if (hs_q != HS_SHIFT) sclk_q <= 1'b1;
      if (falling) din_q <= rst_seq_q | sh_q[39];
      else if (hs_q != HS_SHIFT) din_q <= 1'b1;
      cs_n_q <= ~(hs_q == HS_SHIFT || tie_low_q);
    end
  end
  assign link.sclk = sclk_q;
  assign link.din = din_q;
  assign link.cs_n = cs_n_q;

  // ==========================================================
  // Register port
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wdata_q <= 32'd0;
      tie_low_q <= 1'b0;
      rdata <= 32'd0;
    end else begin
      if (wr && addr == `ADCMCS_HOST_WDATA) wdata_q <= wdata;
      if (wr && addr == `ADCMCS_HOST_CFG) tie_low_q <= wdata[0];
      if (!rd) rdata <= 32'd0;
      else if (addr == `ADCMCS_HOST_WDATA) rdata <= wdata_q;
      else if (addr == `ADCMCS_HOST_RDATA) rdata <= rdata_q;
      else if (addr == `ADCMCS_HOST_STATUS) rdata <= {30'd0, dout_s2_q, hs_q != HS_IDLE};
      else if (addr == `ADCMCS_HOST_CFG) rdata <= {31'd0, tie_low_q};
      else rdata <= 32'd0;
    end
  end
endmodule : adcmcs_host

/* tb/adcmcs_assertions.sv */
/*
  Checker on the serial link wires between the two ends.
  Assumes instantiation beside the link interface, in the ends' clock domain.
*/
`timescale 1ns/1ns
module adcmcs_assertions #(
  parameter int WAIT_CYC = 50
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic dout_line
);
  // ====================
  // Edge and run-of-ones tracking
  logic sclk_q;
  logic [6:0] ones_q;
  logic [9:0] gap_q;
  wire rise = sclk & ~sclk_q;
  wire [6:0] ones_d = (cs_n || (rise && !din)) ? 7'h0 : (rise ? ones_q + 7'h1 : ones_q);
  wire [9:0] gap_d = rise ? 10'h0 : ((&gap_q) ? gap_q : gap_q + 10'h1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      ones_q <= 7'h0;
      gap_q <= 10'h0;
    end else begin
      sclk_q <= sclk;
      ones_q <= ones_d;
      gap_q <= gap_d;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ====================
  // Link properties
  property p_oe_on; $fell(cs_n) |-> ##[1:4] dout_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("data pin not driven after select");
  property p_oe_off; $rose(cs_n) |-> ##[1:4] !dout_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data pin still driven after deselect");
  property p_line_hi; cs_n [*5] |-> dout_line; endproperty
  a_line_hi: assert property (p_line_hi) else $error("ready shown while deselected");
  property p_half; $changed(sclk) |=> $stable(sclk) [*7]; endproperty
  a_half: assert property (p_half) else $error("serial clock half period too short");
  property p_din_set; rise && !cs_n |-> $stable(din); endproperty
  a_din_set: assert property (p_din_set) else $error("data in moved at sampling edge");
  property p_cs_sclk; $changed(sclk) |-> !cs_n; endproperty
  a_cs_sclk: assert property (p_cs_sclk) else $error("serial clock toggled while deselected");
  property p_ones_max; ones_q <= 7'd64; endproperty
  a_ones_max: assert property (p_ones_max) else $error("reset run longer than 64 ones");
  // Host must leave the link idle after the reset run
  property p_wait; rise && ones_q == 7'd64 |-> gap_q >= WAIT_CYC; endproperty
  a_wait: assert property (p_wait) else $error("command too soon after reset run");
endmodule : adcmcs_assertions

/* tb/tb.sv */
/*
  Bench joining controller and converter; an integer model predicts results.
  Assumes the design files and adcmcs_map.svh are compiled ahead of it.
*/
`timescale 1ns/1ns
`include "adcmcs_map.svh"
`define CHK(a, b) chk(48'(a), 48'(b))
module tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic signed [23:0] raw_code = 24'h0;
  logic [1:0] conv_channel;
  logic conv_active, ain_pos_connected, ref_on, xtal_on, gpio_hiz, powered_down;
  logic [31:0] q;
  longint r, off;
  longint exp_q[$];
  int cm[3] = '{4, 6, 7};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  adcmcs_if u_adcmcs_if();
  adcmcs_device #(.SETTLE_CYC(1000)) u_adcmcs_device (.clock(clock), .rst_b(rst_b), .link(u_adcmcs_if),
    .raw_code(raw_code), .conv_channel(conv_channel), .conv_active(conv_active),
    .ain_pos_connected(ain_pos_connected), .ref_on(ref_on), .xtal_on(xtal_on), .gpio_hiz(gpio_hiz),
    .powered_down(powered_down));
  adcmcs_host #(.SCLK_HALF(8), .RESET_WAIT_CYC(50)) u_adcmcs_host (.clock(clock), .rst_b(rst_b),
    .link(u_adcmcs_if), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  adcmcs_assertions #(.WAIT_CYC(50)) u_adcmcs_assertions (.clock(clock), .rst_b(rst_b),
    .cs_n(u_adcmcs_if.cs_n), .sclk(u_adcmcs_if.sclk), .din(u_adcmcs_if.din), .dout(u_adcmcs_if.dout),
    .dout_oe(u_adcmcs_if.dout_oe), .dout_line(u_adcmcs_if.dout_line));
  initial forever #5 clock = ~clock;
  // ====================
  // Checking and verdict
  task automatic chk(input logic [47:0] g, input logic [47:0] x);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task conclude;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Bipolar scaling; operands kept positive so truncation is unambiguous
  function automatic longint scale(longint rw, longint o, longint g);
    return (rw - (o - 'h80_0000)) * g / 'h40_0000 + 'h80_0000;
  endfunction : scale
  // ====================
  // Register port and link transfers
  task bw(input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : bw
  task br(input logic [2:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : br
  task automatic wt;
    int n;
    logic [31:0] s;
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 3000) begin
      br(`ADCMCS_HOST_STATUS, s);
      n++;
    end
    `CHK(s[0], 1'b0);
  endtask : wt
  task xf(input logic [5:0] ra, input logic rdb, input logic [5:0] len, input logic [31:0] d);
    bw(`ADCMCS_HOST_WDATA, d);
    bw(`ADCMCS_HOST_CTRL, {18'h0, len, 1'b0, rdb, ra});
    wt();
    // Converter acts on the last bit a few clocks after the host goes idle
    repeat (4) @(posedge clock);
    br(`ADCMCS_HOST_RDATA, q);
  endtask : xf
  task automatic cv;
    int n;
    n = 0;
    while (conv_active !== 1'b0 && n < 5000) begin
      @(posedge clock);
      n++;
    end
    // Let the final ready level pass both synchronisers
    repeat (8) @(posedge clock);
    `CHK(conv_active, 1'b0);
  endtask : cv
  // ====================
  // Scenarios
  initial begin
    void'($urandom(32'h6a73_5b08));
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    xf(`ADCMCS_ADDR_OFFSET, 1, 24, 0);
    `CHK(q[23:0], 24'h80_0000);
    xf(`ADCMCS_ADDR_GAIN, 1, 24, 0);
    `CHK(q[23:0], 24'h55_5555);
    `CHK({ref_on, xtal_on}, 2'b10);
    bw(`ADCMCS_HOST_CFG, 32'h1);
    xf(`ADCMCS_ADDR_MODE, 0, 16, 32'h2c);
    `CHK({ref_on, xtal_on}, 2'b01);
    xf(`ADCMCS_ADDR_MODE, 0, 16, 32'h8050);
    xf(`ADCMCS_ADDR_MODE, 1, 16, 0);
    `CHK(q[15:0], 16'h002c);
    for (int m = 0; m < 3; m++) begin
      r = (cm[m] == 7) ? off - 'h80_0000 + 'h40_0000 : $urandom & 'h0f_ffff;
      raw_code <= 24'(r);
      xf(`ADCMCS_ADDR_MODE, 0, 16, 32'h8000 | (cm[m] << 4));
      `CHK(ain_pos_connected, cm[m] != 4);
      xf(`ADCMCS_ADDR_STATUS, 1, 8, 0);
      `CHK(q[7], 1'b1);
      cv();
      xf(`ADCMCS_ADDR_STATUS, 1, 8, 0);
      `CHK(q[7], 1'b0);
      if (m < 2) off = r + 'h80_0000;
      xf(m < 2 ? `ADCMCS_ADDR_OFFSET : `ADCMCS_ADDR_GAIN, 1, 24, 0);
      `CHK(q[23:0], m < 2 ? off : `ADCMCS_FS_NUM / 'h40_0000);
      xf(`ADCMCS_ADDR_MODE, 1, 16, 0);
      `CHK(q[6:4], 3'h2);
    end
    xf(`ADCMCS_ADDR_OFFSET, 0, 24, 32'h80_0000);
    off = 'h80_0000;
    r = $urandom & 'h1f_ffff;
    raw_code <= 24'(r);
    exp_q.push_back(scale(r, off, 'h80_0000));
    xf(`ADCMCS_ADDR_CHEN, 0, 8, 32'h13);
    xf(`ADCMCS_ADDR_IFMODE, 0, 16, 32'h40);
    xf(`ADCMCS_ADDR_MODE, 0, 16, 32'h8010);
    br(`ADCMCS_HOST_STATUS, q);
    `CHK(q[1], 1'b1);
    xf(`ADCMCS_ADDR_MODE, 0, 16, 32'h8030);
    cv();
    `CHK(powered_down, 1'b0);
    br(`ADCMCS_HOST_STATUS, q);
    `CHK(q[1], 1'b0);
    xf(`ADCMCS_ADDR_DATA, 1, 32, 0);
    `CHK(q, {exp_q[0][23:0], 8'h01});
    br(`ADCMCS_HOST_STATUS, q);
    `CHK(q[1], 1'b1);
    xf(`ADCMCS_ADDR_DATA, 1, 32, 0);
    r = exp_q.pop_front();
    `CHK(q, {r[23:0], 8'h81});
    xf(`ADCMCS_ADDR_MODE, 1, 16, 0);
    `CHK(q[15:0], 16'h8020);
    xf(`ADCMCS_ADDR_OFFSET, 0, 24, 32'h12_3456);
    xf(`ADCMCS_ADDR_OFFSET, 1, 24, 0);
    `CHK(q[23:0], 24'h12_3456);
    xf(`ADCMCS_ADDR_MODE, 0, 16, 32'h8030);
    `CHK({powered_down, gpio_hiz}, 2'b11);
    bw(`ADCMCS_HOST_CTRL, 32'h80);
    wt();
    `CHK(powered_down, 1'b0);
    xf(`ADCMCS_ADDR_OFFSET, 1, 24, 0);
    `CHK(q[23:0], 24'h80_0000);
    xf(`ADCMCS_ADDR_IFMODE, 1, 16, 0);
    `CHK(q[15:0], 16'h0);
    conclude();
  end
endmodule : tb
